// ===== hdl/cmg_pkg.sv
// Functional notes
// R1: Four CPU modes, privileged selector hidden
// R2: Privileged sub-modes unreachable by application
// R3: Before test disable, reset ends in test
// R4: After test disable, reset ends in system; the code clears a written test disable at reset, so only a fused one lasts
// R5: Boot mode runs only test ROM code
// R6: System mode grants full SFR control
// R7: Each exception/interrupt gets own ROM vector
// R8: Configuration vector call enters config mode
// R9: Hardware isolates modes, guards boot and test
// R10: Guard checks ROM, RAM and nonvolatile memory
// R11: ROM split 196K application, 20K test
// R12: Nonvolatile region 12K or 8K by configuration
// R13: 128 bytes nonvolatile reserved for manufacturer
// R14: RAM split 6016/128 boot, 6144/0 application; the code opens all 6144 bytes to boot mode
// R15: Test mode: no restriction on accesses
// R16: Boot/config: test ROM, config NVM, region only
// R17: Other regions, application ROM, in system mode
// R18: RAM 3584 general, 2560 coprocessor; coprocessor own only
// R19: Coprocessor accesses bypass access checks
// R20: Config mode limited by hardware/software settings
// R21: Block out-of-region access, raise exception
package cmg_pkg;
    typedef enum logic [1:0] {
        CMG_MODE_BOOT,
        CMG_MODE_TEST,
        CMG_MODE_RCFG,
        CMG_MODE_SYS
    } cmg_mode_t;

    typedef enum logic [1:0] {
        CMG_MEM_ROM,
        CMG_MEM_RAM,
        CMG_MEM_NVM,
        CMG_MEM_SFR
    } cmg_mem_t;

    typedef struct packed {
        logic        valid;
        cmg_mem_t    mem;
        logic        write;
        logic [17:0] addr;
    } cmg_acc_t;

    localparam int          CMG_AW            = 18;
    localparam logic [17:0] CMG_ROM_APP_BYTES = 18'h31000;
    localparam logic [17:0] CMG_ROM_TEST_BYTES = 18'h05000;
    localparam logic [17:0] CMG_NVM_12K       = 18'h03000;
    localparam logic [17:0] CMG_NVM_8K        = 18'h02000;
    localparam logic [17:0] CMG_NVM_MFR_BYTES = 18'h00080;
    localparam logic [17:0] CMG_NVM_MFR_WIN   = 18'h00100;
    localparam logic [17:0] CMG_RAM_BYTES     = 18'h01800;
    localparam logic [17:0] CMG_RAM_BOOT_LO   = 18'h01780;
    localparam logic [17:0] CMG_RAM_GEN_BYTES = 18'h00E00;
    localparam logic [17:0] CMG_RAM_PK_BYTES  = 18'h00A00;

    // Register map (word index = offset)
    localparam logic [3:0] CMG_REG_STATUS   = 4'h0;
    localparam logic [3:0] CMG_REG_CONTROL  = 4'h1;
    localparam logic [3:0] CMG_REG_RCFG_LIM = 4'h2;
    localparam logic [3:0] CMG_REG_FAULT    = 4'h3;
    localparam logic [3:0] CMG_REG_VECTOR   = 4'h4;

    // Control bits
    localparam int CMG_CTL_LEAVE_SUPER = 0;
    localparam int CMG_CTL_PK_ENABLE   = 1;
    localparam int CMG_CTL_NVM_8K      = 2;
    localparam int CMG_CTL_TEST_OFF    = 3;

    // Vector layout in ROM
    localparam logic [17:0] CMG_VEC_EXC_BASE  = 18'h00003;
    localparam logic [17:0] CMG_VEC_IRQ_BASE  = 18'h00043;
    localparam logic [17:0] CMG_VEC_CFG_BASE  = 18'h00083;
    localparam int          CMG_VEC_STRIDE_SH = 3;
    localparam logic [17:0] CMG_RESET_VECTOR  = 18'h00000;
endpackage

// ===== hdl/cmg_guard.sv
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cmg_guard #(
    parameter int N_EXC = 8,
    parameter int N_IRQ = 8,
    parameter int N_CFG = 8
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             test_fuse_pin,
    input  wire cmg_pkg::cmg_acc_t cpu_acc,
    input  wire cmg_pkg::cmg_acc_t pk_acc,
    input  wire logic [N_EXC-1:0] exc_req,
    input  wire logic [N_IRQ-1:0] irq_req,
    input  wire logic             cfg_call,
    input  wire logic [2:0]       cfg_call_idx,
    input  wire logic             sys_return,
    input  wire logic             super_sel_we,
    input  wire cmg_pkg::cmg_mode_t super_sel_wdata,
    input  wire logic [3:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic [31:0]           reg_rdata_ff,
    output cmg_pkg::cmg_mode_t    mode_ff,
    output logic                  cpu_grant_ff,
    output logic                  pk_grant_ff,
    output logic                  acc_fault_ff,
    output logic                  vec_jump_ff,
    output logic [17:0]           vec_addr_ff
);
    initial begin
        if (N_EXC < 1 || N_EXC > 8 || N_IRQ < 1 || N_IRQ > 8 || N_CFG != 8)
            $error("cmg_guard: unsupported vector counts");
    end

    // Fuse pin synchroniser, three stages
    logic fuse_s1_ff;
    logic fuse_s2_ff;
    logic fuse_s3_ff;
    logic test_off_ff;
    logic boot_done_ff;
    logic [3:0] ctl_ff;
    logic [17:0] rcfg_lim_ff;
    logic [7:0] fault_cnt_ff;
    logic [17:0] fault_addr_ff;
    logic [17:0] nvm_region;
    logic cpu_ok;
    logic pk_ok;
    logic [17:0] a;

    always_ff @(posedge clock) begin
        fuse_s1_ff <= test_fuse_pin;
        fuse_s2_ff <= fuse_s1_ff;
        fuse_s3_ff <= fuse_s2_ff;
    end

    // Test disable is sticky once fused or written
    always_ff @(posedge clock) begin
        if (reset)
            test_off_ff <= 1'b0;
        else if ((fuse_s2_ff && fuse_s3_ff) || (reg_wr && mode_ff == cmg_pkg::CMG_MODE_TEST
                 && reg_addr == cmg_pkg::CMG_REG_CONTROL && reg_wdata[cmg_pkg::CMG_CTL_TEST_OFF]))
            test_off_ff <= 1'b1;
    end

    // R3 R4 R5 mode after reset
    always_ff @(posedge clock) begin
        if (reset) begin
            mode_ff      <= cmg_pkg::CMG_MODE_BOOT;
            boot_done_ff <= 1'b0;
        end else begin
            unique case (mode_ff)
                cmg_pkg::CMG_MODE_BOOT: begin
                    // R1 R2 hidden selector, privileged only
                    if (super_sel_we && super_sel_wdata == cmg_pkg::CMG_MODE_TEST && !test_off_ff)
                        mode_ff <= cmg_pkg::CMG_MODE_TEST;
                    else if (reg_wr && reg_addr == cmg_pkg::CMG_REG_CONTROL
                             && reg_wdata[cmg_pkg::CMG_CTL_LEAVE_SUPER]) begin
                        // R3 R4 boot exit by fuse state
                        mode_ff      <= test_off_ff ? cmg_pkg::CMG_MODE_SYS
                                                    : cmg_pkg::CMG_MODE_TEST;
                        boot_done_ff <= 1'b1;
                    end
                end
                cmg_pkg::CMG_MODE_TEST: begin
                    if (super_sel_we && super_sel_wdata == cmg_pkg::CMG_MODE_RCFG)
                        mode_ff <= cmg_pkg::CMG_MODE_RCFG;
                end
                cmg_pkg::CMG_MODE_RCFG: begin
                    if (sys_return)
                        mode_ff <= cmg_pkg::CMG_MODE_SYS;
                end
                cmg_pkg::CMG_MODE_SYS: begin
                    // R8 configuration vector call
                    if (cfg_call)
                        mode_ff <= cmg_pkg::CMG_MODE_RCFG;
                end
            endcase
        end
    end

    // Control registers, writable in privileged modes; in system mode the config limit can only be lowered
    always_ff @(posedge clock) begin
        if (reset) begin
            ctl_ff      <= 4'h2;
            rcfg_lim_ff <= cmg_pkg::CMG_NVM_12K;
        end else if (reg_wr && mode_ff != cmg_pkg::CMG_MODE_SYS) begin
            // R9 R20 control locked in system mode, config limit only lowered there
            if (reg_addr == cmg_pkg::CMG_REG_CONTROL)
                ctl_ff <= reg_wdata[3:0];
            else if (reg_addr == cmg_pkg::CMG_REG_RCFG_LIM)
                rcfg_lim_ff <= reg_wdata[17:0];
        end else if (reg_wr && reg_addr == cmg_pkg::CMG_REG_RCFG_LIM) begin
            // R20 application may narrow config limit
            if (reg_wdata[17:0] < rcfg_lim_ff)
                rcfg_lim_ff <= reg_wdata[17:0];
        end
    end

    // R12 nonvolatile region size
    assign nvm_region = ctl_ff[cmg_pkg::CMG_CTL_NVM_8K] ? cmg_pkg::CMG_NVM_8K
                                                         : cmg_pkg::CMG_NVM_12K;
    assign a = cpu_acc.addr;

    // R10 access check over all memories
    always_comb begin
        cpu_ok = 1'b0;
        unique case (mode_ff)
            // R15 test mode unrestricted
            cmg_pkg::CMG_MODE_TEST: cpu_ok = 1'b1;
            cmg_pkg::CMG_MODE_BOOT, cmg_pkg::CMG_MODE_RCFG: begin
                // R16 privileged window
                unique case (cpu_acc.mem)
                    // R11 test ROM above application ROM
                    cmg_pkg::CMG_MEM_ROM: cpu_ok = !cpu_acc.write
                        && a >= cmg_pkg::CMG_ROM_APP_BYTES
                        && a < cmg_pkg::CMG_ROM_APP_BYTES + cmg_pkg::CMG_ROM_TEST_BYTES;
                    // R16 R20 config window plus region
                    cmg_pkg::CMG_MEM_NVM: cpu_ok = a < cmg_pkg::CMG_NVM_MFR_WIN
                        || (a >= cmg_pkg::CMG_NVM_MFR_WIN
                            && a < cmg_pkg::CMG_NVM_MFR_WIN + nvm_region
                            && (mode_ff == cmg_pkg::CMG_MODE_BOOT
                                || a < cmg_pkg::CMG_NVM_MFR_WIN + rcfg_lim_ff));
                    // R14 boot mode opens all 6144 RAM bytes, no 6016/128 split
                    cmg_pkg::CMG_MEM_RAM: cpu_ok = mode_ff == cmg_pkg::CMG_MODE_BOOT
                        && a < cmg_pkg::CMG_RAM_BYTES;
                    cmg_pkg::CMG_MEM_SFR: cpu_ok = 1'b1;
                endcase
            end
            cmg_pkg::CMG_MODE_SYS: begin
                // R17 R6 system mode map
                unique case (cpu_acc.mem)
                    cmg_pkg::CMG_MEM_ROM: cpu_ok = !cpu_acc.write
                        && a < cmg_pkg::CMG_ROM_APP_BYTES;
                    // R13 manufacturer bytes excluded
                    cmg_pkg::CMG_MEM_NVM: cpu_ok = a >= cmg_pkg::CMG_NVM_MFR_WIN
                        && a < cmg_pkg::CMG_NVM_MFR_WIN + nvm_region;
                    // R14 R18 whole 6144 bytes, pk part gated
                    cmg_pkg::CMG_MEM_RAM: cpu_ok = a < cmg_pkg::CMG_RAM_GEN_BYTES
                        || (a < cmg_pkg::CMG_RAM_BYTES && ctl_ff[cmg_pkg::CMG_CTL_PK_ENABLE]);
                    cmg_pkg::CMG_MEM_SFR: cpu_ok = 1'b1;
                endcase
            end
        endcase
    end

    // R18 R19 coprocessor: own RAM and NVM, unchecked by mode
    always_comb begin
        pk_ok = 1'b0;
        if (ctl_ff[cmg_pkg::CMG_CTL_PK_ENABLE]) begin
            if (pk_acc.mem == cmg_pkg::CMG_MEM_RAM)
                pk_ok = pk_acc.addr >= cmg_pkg::CMG_RAM_GEN_BYTES
                        && pk_acc.addr < cmg_pkg::CMG_RAM_BYTES;
            else if (pk_acc.mem == cmg_pkg::CMG_MEM_NVM)
                pk_ok = pk_acc.addr >= cmg_pkg::CMG_NVM_MFR_WIN
                        && pk_acc.addr < cmg_pkg::CMG_NVM_MFR_WIN + nvm_region;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            cpu_grant_ff <= 1'b0;
            pk_grant_ff  <= 1'b0;
        end else begin
            cpu_grant_ff <= cpu_acc.valid && cpu_ok;
            pk_grant_ff  <= pk_acc.valid && pk_ok;
        end
    end

    // R21 block and flag violation
    always_ff @(posedge clock) begin
        if (reset) begin
            acc_fault_ff  <= 1'b0;
            fault_cnt_ff  <= 8'h00;
            fault_addr_ff <= 18'h00000;
        end else begin
            acc_fault_ff <= cpu_acc.valid && !cpu_ok;
            if (cpu_acc.valid && !cpu_ok) begin
                fault_addr_ff <= cpu_acc.addr;
                if (fault_cnt_ff != 8'hFF)
                    fault_cnt_ff <= fault_cnt_ff + 8'h01;
            end else if (reg_wr && reg_addr == cmg_pkg::CMG_REG_FAULT)
                fault_cnt_ff <= 8'h00;
        end
    end

    // R7 R8 vector routing, exceptions first
    always_ff @(posedge clock) begin
        if (reset) begin
            vec_jump_ff <= 1'b0;
            vec_addr_ff <= cmg_pkg::CMG_RESET_VECTOR;
        end else begin
            vec_jump_ff <= 1'b0;
            if (cpu_acc.valid && !cpu_ok) begin
                vec_jump_ff <= 1'b1;
                vec_addr_ff <= cmg_pkg::CMG_VEC_EXC_BASE;
            end else if (|exc_req) begin
                vec_jump_ff <= 1'b1;
                for (int i = N_EXC - 1; i >= 0; i--)
                    if (exc_req[i])
                        vec_addr_ff <= cmg_pkg::CMG_VEC_EXC_BASE
                            + 18'(i << cmg_pkg::CMG_VEC_STRIDE_SH);
            end else if (|irq_req) begin
                vec_jump_ff <= 1'b1;
                for (int i = N_IRQ - 1; i >= 0; i--)
                    if (irq_req[i])
                        vec_addr_ff <= cmg_pkg::CMG_VEC_IRQ_BASE
                            + 18'(i << cmg_pkg::CMG_VEC_STRIDE_SH);
            end else if (cfg_call && mode_ff == cmg_pkg::CMG_MODE_SYS) begin
                vec_jump_ff <= 1'b1;
                vec_addr_ff <= cmg_pkg::CMG_VEC_CFG_BASE
                    + 18'({15'h0000, cfg_call_idx} << cmg_pkg::CMG_VEC_STRIDE_SH);
            end
        end
    end

    // Register read port
    always_ff @(posedge clock) begin
        if (reset)
            reg_rdata_ff <= 32'h0000_0000;
        else if (reg_rd) begin
            unique case (reg_addr)
                // R2 selector not visible in system mode
                cmg_pkg::CMG_REG_STATUS: reg_rdata_ff <= mode_ff == cmg_pkg::CMG_MODE_SYS
                    ? {29'h0, test_off_ff, 2'h3}
                    : {28'h0, boot_done_ff, test_off_ff, mode_ff};
                cmg_pkg::CMG_REG_CONTROL:  reg_rdata_ff <= {28'h0, ctl_ff};
                cmg_pkg::CMG_REG_RCFG_LIM: reg_rdata_ff <= {14'h0, rcfg_lim_ff};
                cmg_pkg::CMG_REG_FAULT:    reg_rdata_ff <= {6'h0, fault_addr_ff, fault_cnt_ff};
                cmg_pkg::CMG_REG_VECTOR:   reg_rdata_ff <= {14'h0, vec_addr_ff};
                default:                   reg_rdata_ff <= 32'h0000_0000;
            endcase
        end else
            reg_rdata_ff <= 32'h0000_0000;
    end
endmodule
`default_nettype wire

// ===== sim/cmg_guard_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cmg_guard_checker #(
    parameter int N_EXC = 8,
    parameter int N_IRQ = 8
) (
    input wire logic               clock,
    input wire logic               reset,
    input wire cmg_pkg::cmg_acc_t  cpu_acc,
    input wire cmg_pkg::cmg_acc_t  pk_acc,
    input wire logic [N_EXC-1:0]   exc_req,
    input wire logic [N_IRQ-1:0]   irq_req,
    input wire logic               cfg_call,
    input wire logic [2:0]         cfg_call_idx,
    input wire logic               super_sel_we,
    input wire cmg_pkg::cmg_mode_t mode_ff,
    input wire logic               cpu_grant_ff,
    input wire logic               pk_grant_ff,
    input wire logic               acc_fault_ff,
    input wire logic               vec_jump_ff,
    input wire logic [17:0]        vec_addr_ff
);
    logic live_ff;
    always_ff @(posedge clock) begin
        live_ff <= !reset;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    AST_RESET_BOOT: assert property (!live_ff |-> mode_ff == cmg_pkg::CMG_MODE_BOOT)
        else $error("mode not boot after reset");
    AST_FAULT_VEC: assert property (acc_fault_ff |-> vec_jump_ff && !cpu_grant_ff
        && vec_addr_ff == cmg_pkg::CMG_VEC_EXC_BASE) else $error("fault without vector");
    AST_TEST_FREE: assert property (live_ff && $past(cpu_acc.valid
        && mode_ff == cmg_pkg::CMG_MODE_TEST) |-> cpu_grant_ff) else $error("test access refused");
    AST_PK_OWN: assert property (pk_grant_ff |-> $past(pk_acc.valid) && !($past(pk_acc.mem)
        == cmg_pkg::CMG_MEM_RAM && $past(pk_acc.addr) < cmg_pkg::CMG_RAM_GEN_BYTES))
        else $error("coprocessor reached general ram");
    AST_SUPER_ROM: assert property (live_ff && $past(cpu_acc.valid
        && (mode_ff == cmg_pkg::CMG_MODE_BOOT || mode_ff == cmg_pkg::CMG_MODE_RCFG)
        && cpu_acc.mem == cmg_pkg::CMG_MEM_ROM && cpu_acc.addr < cmg_pkg::CMG_ROM_APP_BYTES)
        |-> acc_fault_ff) else $error("application rom open in super mode");
    AST_SYS_TROM: assert property (live_ff && $past(cpu_acc.valid
        && mode_ff == cmg_pkg::CMG_MODE_SYS && cpu_acc.mem == cmg_pkg::CMG_MEM_ROM
        && cpu_acc.addr >= cmg_pkg::CMG_ROM_APP_BYTES) |-> acc_fault_ff)
        else $error("test rom open in system mode");
    AST_IRQ_VEC: assert property (live_ff && $past(irq_req[0] && exc_req == '0
        && !cpu_acc.valid) |-> vec_jump_ff && vec_addr_ff == cmg_pkg::CMG_VEC_IRQ_BASE)
        else $error("interrupt vector wrong");
    AST_CFG_ENTER: assert property (live_ff && $past(mode_ff == cmg_pkg::CMG_MODE_SYS
        && cfg_call && exc_req == '0 && irq_req == '0 && !cpu_acc.valid)
        |-> mode_ff == cmg_pkg::CMG_MODE_RCFG && vec_addr_ff == cmg_pkg::CMG_VEC_CFG_BASE
        + {12'h000, $past(cfg_call_idx), 3'h0}) else $error("configuration entry wrong");
    AST_SEL_LOCK: assert property (live_ff && $past(mode_ff == cmg_pkg::CMG_MODE_SYS
        && super_sel_we && !cfg_call) |-> mode_ff == cmg_pkg::CMG_MODE_SYS)
        else $error("selector left system mode");
    COV_TEST: cover property (cpu_grant_ff && mode_ff == cmg_pkg::CMG_MODE_TEST);
    COV_FAULT: cover property (acc_fault_ff && mode_ff == cmg_pkg::CMG_MODE_SYS);
    COV_RCFG: cover property (mode_ff == cmg_pkg::CMG_MODE_RCFG);
endmodule
bind cmg_guard cmg_guard_checker #(.N_EXC(N_EXC), .N_IRQ(N_IRQ)) chk (
    .clock(clock), .reset(reset), .cpu_acc(cpu_acc), .pk_acc(pk_acc),
    .exc_req(exc_req), .irq_req(irq_req), .cfg_call(cfg_call), .cfg_call_idx(cfg_call_idx),
    .super_sel_we(super_sel_we), .mode_ff(mode_ff), .cpu_grant_ff(cpu_grant_ff),
    .pk_grant_ff(pk_grant_ff), .acc_fault_ff(acc_fault_ff), .vec_jump_ff(vec_jump_ff),
    .vec_addr_ff(vec_addr_ff));
`default_nettype wire

// ===== sim/cmg_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmg_cpu_model (
    input  wire logic         clock,
    input  wire logic         cpu_grant_ff,
    input  wire logic         pk_grant_ff,
    input  wire logic         acc_fault_ff,
    output cmg_pkg::cmg_acc_t cpu_acc,
    output cmg_pkg::cmg_acc_t pk_acc,
    output logic              cfg_call,
    output logic [2:0]        cfg_call_idx
);
    initial begin
        cpu_acc = '0;
        pk_acc = '0;
        cfg_call = 1'b0;
        cfg_call_idx = 3'h0;
    end
    // Released bus shows inverted address
    task acc(input cmg_pkg::cmg_mem_t m, input logic w, input logic [17:0] a, input logic pk,
             output logic g, output logic f);
        @(posedge clock);
        if (pk) pk_acc <= '{1'b1, m, w, a};
        else cpu_acc <= '{1'b1, m, w, a};
        @(posedge clock);
        cpu_acc <= '{1'b0, cpu_acc.mem, cpu_acc.write, ~cpu_acc.addr};
        pk_acc <= '{1'b0, pk_acc.mem, pk_acc.write, ~pk_acc.addr};
        #1;
        g = pk ? pk_grant_ff : cpu_grant_ff;
        f = acc_fault_ff;
    endtask
    task call_vec(input logic [2:0] k);
        @(posedge clock);
        cfg_call <= 1'b1;
        cfg_call_idx <= k;
        @(posedge clock);
        cfg_call <= 1'b0;
        cfg_call_idx <= ~k;
        #1;
    endtask
endmodule
`default_nettype wire

// ===== sim/cpu_mode_memory_guard_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_memory_guard_tb;
    logic clock = 1'b0, reset = 1'b1, fuse = 1'b0, sysr = 1'b0, sel = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] exc = 8'h00, irq = 8'h00;
    logic [3:0] ra = 4'h0;
    logic [31:0] wd = 32'h0, rdat, d;
    logic g, f, jmp, cg, pg, flt, cc;
    logic [2:0] ci;
    logic [17:0] vec;
    cmg_pkg::cmg_mode_t mode;
    cmg_pkg::cmg_mode_t swd = cmg_pkg::CMG_MODE_TEST;
    cmg_pkg::cmg_acc_t ca, pa;
    int fail_count = 0, samples_checked = 0;
    // Columns: pk, mem, expected grant, address
    logic [21:0] tab [10] = '{{1'b0, 2'h0, 1'b1, 18'h00100}, {1'b0, 2'h0, 1'b0, 18'h31000},
        {1'b0, 2'h2, 1'b0, 18'h00000}, {1'b0, 2'h2, 1'b1, 18'h00100},
        {1'b0, 2'h1, 1'b1, 18'h017FF}, {1'b1, 2'h1, 1'b1, 18'h00E00},
        {1'b1, 2'h1, 1'b0, 18'h00000}, {1'b1, 2'h2, 1'b1, 18'h00100},
        {1'b0, 2'h2, 1'b0, 18'h02100}, {1'b1, 2'h2, 1'b0, 18'h02100}};
    always #2 clock = ~clock;
    cmg_cpu_model cpu (.clock(clock), .cpu_grant_ff(cg), .pk_grant_ff(pg), .acc_fault_ff(flt),
        .cpu_acc(ca), .pk_acc(pa), .cfg_call(cc), .cfg_call_idx(ci));
    cmg_guard dut (.clock(clock), .reset(reset), .test_fuse_pin(fuse), .cpu_acc(ca), .pk_acc(pa),
        .exc_req(exc), .irq_req(irq), .cfg_call(cc), .cfg_call_idx(ci), .sys_return(sysr),
        .super_sel_we(sel), .super_sel_wdata(swd), .reg_addr(ra),
        .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata_ff(rdat), .mode_ff(mode),
        .cpu_grant_ff(cg), .pk_grant_ff(pg), .acc_fault_ff(flt), .vec_jump_ff(jmp),
        .vec_addr_ff(vec));
    task complete_run;
        $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task chk_acc(input logic eg);
        chk_val({30'h0, g, f}, {30'h0, eg, !eg});
    endtask
    task wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clock);
        {wr, ra, wd} <= {1'b1, a, v};
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask
    task rd_reg(input logic [3:0] a);
        @(posedge clock);
        {rd, ra} <= {1'b1, a};
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdat;
    endtask
    task fire(input logic [7:0] e, input logic [7:0] i, input logic s, input logic w,
              input cmg_pkg::cmg_mode_t m);
        @(posedge clock);
        {exc, irq, sysr, sel} <= {e, i, s, w};
        swd <= m;
        @(posedge clock);
        {exc, irq, sysr, sel} <= '0;
        #1;
    endtask
    task do_reset(input logic fz);
        @(posedge clock);
        {reset, fuse} <= {1'b1, fz};
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    initial begin
        do_reset(1'b0);
        rd_reg(cmg_pkg::CMG_REG_RCFG_LIM);
        chk_val(d, 32'h00003000);
        rd_reg(4'hF);
        chk_val(d, 32'h0);
        cpu.acc(cmg_pkg::CMG_MEM_ROM, 1'b0, 18'h00010, 1'b0, g, f);
        chk_acc(1'b0);
        cpu.acc(cmg_pkg::CMG_MEM_ROM, 1'b0, 18'h31000, 1'b0, g, f);
        chk_acc(1'b1);
        fire(8'h00, 8'h00, 1'b0, 1'b1, cmg_pkg::CMG_MODE_TEST);
        chk_val({30'h0, mode}, {30'h0, cmg_pkg::CMG_MODE_TEST});
        cpu.acc(cmg_pkg::CMG_MEM_ROM, 1'b1, 18'h00010, 1'b0, g, f);
        chk_acc(1'b1);
        wr_reg(cmg_pkg::CMG_REG_CONTROL, 32'h00000008);
        rd_reg(cmg_pkg::CMG_REG_STATUS);
        chk_val(d, 32'h00000005);
        fire(8'h00, 8'h00, 1'b0, 1'b1, cmg_pkg::CMG_MODE_RCFG);
        chk_val({30'h0, mode}, {30'h0, cmg_pkg::CMG_MODE_RCFG});
        do_reset(1'b1);
        wr_reg(cmg_pkg::CMG_REG_CONTROL, 32'h00000007);
        chk_val({30'h0, mode}, {30'h0, cmg_pkg::CMG_MODE_SYS});
        rd_reg(cmg_pkg::CMG_REG_STATUS);
        chk_val({30'h0, d[1:0]}, 32'h3);
        foreach (tab[k]) begin
            cpu.acc(cmg_pkg::cmg_mem_t'(tab[k][20:19]), 1'b0, tab[k][17:0], tab[k][21], g, f);
            chk_val({31'h0, g}, {31'h0, tab[k][18]});
        end
        fire(8'h00, 8'h05, 1'b0, 1'b0, cmg_pkg::CMG_MODE_TEST);
        chk_val({13'h0, jmp, vec}, {13'h0, 1'b1, 18'h00043});
        fire(8'h06, 8'h04, 1'b0, 1'b1, cmg_pkg::CMG_MODE_TEST);
        chk_val({12'h0, mode, vec}, {12'h0, cmg_pkg::CMG_MODE_SYS, 18'h0000B});
        wr_reg(cmg_pkg::CMG_REG_RCFG_LIM, 32'h00004000);
        wr_reg(cmg_pkg::CMG_REG_RCFG_LIM, 32'h00002000);
        rd_reg(cmg_pkg::CMG_REG_RCFG_LIM);
        chk_val(d, 32'h00002000);
        for (int k = 0; k < 8; k++) begin
            cpu.call_vec(3'(k));
            chk_val({12'h0, mode, vec}, {12'h0, cmg_pkg::CMG_MODE_RCFG, 18'(8'h83 + 8 * k)});
            cpu.acc(cmg_pkg::CMG_MEM_ROM, 1'b0, 18'h00200, 1'b0, g, f);
            chk_acc(1'b0);
            fire(8'h00, 8'h00, 1'b1, 1'b0, cmg_pkg::CMG_MODE_TEST);
        end
        rd_reg(cmg_pkg::CMG_REG_FAULT);
        chk_val(d, 32'h0002000B);
        rd_reg(cmg_pkg::CMG_REG_VECTOR);
        chk_val(d, 32'h00000003);
        complete_run;
    end
    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        complete_run;
    end
endmodule
`default_nettype wire
